// ---- src/sbs_ctrl.sv ----
// Synchronous control logic of a pipelined burst static memory.
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "sbs_regs.svh"

// Notes on behaviour
// - A write needs global or byte write enable; global low writes every lane.
// - Global high, byte gate low: write exactly the lanes whose enable is low.
// - Read cycles drive every present byte lane regardless of lane enables.
// - Data drivers stay off during every write cycle.
// - Lanes three and four exist only in the wide configuration.
// - Deselect on partial enable with a strobe, or first high with ctrl strobe.
// - Fully enabled with processor strobe low starts a read burst.
// - Controller strobe load starts a write or read burst per write decode.
// - Both strobes high with advance low uses the next burst address.
// - Advance high suspends the burst, keeping the current address.
// - Continue and suspend ignore enables two, three; first high masks proc strobe.
// - Output enable acts asynchronously and only gates synchronous read drive.
// - Dummy reads with output enable high still advance the burst counter.
// - Two-bit counter from address LSBs steps four and wraps on fifth clock.
// - Order pin low is linear modulo four, high is start XOR step.
// - Flow-through pin low bypasses the output register, high pipelines reads.
module sbs_ctrl (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SBS_WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Chip enables and strobes
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    // Write controls
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic lane0_write_n,
    input wire logic lane1_write_n,
    input wire logic lane2_write_n,
    input wire logic lane3_write_n,
    // Mode pins and output enable
    input wire logic flow_through_sel_n,
    input wire logic linear_order_sel_n,
    input wire logic output_enable_n,
    // Address and data pins
    input wire logic [`SBS_ADDR_W-1:0] addr_in,
    input wire logic [`SBS_DATA_W-1:0] dq_in,
    output logic [`SBS_DATA_W-1:0] dq_out,
    output logic [`SBS_LANES-1:0] dq_oe,
    // Array side
    output logic [`SBS_ADDR_W-1:0] mem_addr_q,
    output logic mem_rd_q,
    output logic [`SBS_LANES-1:0] mem_wr_lane_q,
    output logic [`SBS_DATA_W-1:0] mem_wdata_q,
    input wire logic [`SBS_DATA_W-1:0] mem_rdata
);

    logic narrow_q;
    logic [`SBS_ADDR_W-1:0] base_q;
    sbs_pkg::sbs_step_t step_q;
    sbs_pkg::sbs_cycle_e kind_q;
    logic wr_q;
    logic rd2_q;
    logic [`SBS_DATA_W-1:0] rdata_q;
    logic ack_q;
    logic [31:0] dat_q;

    // Enable and strobe decode
    wire chip_full = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
    wire any_strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    wire desel = (!chip_sel_first_n && !chip_full && any_strobe)
        || (chip_sel_first_n && !ctrl_addr_strobe_n);
    wire rd_begin = chip_full && !proc_addr_strobe_n;
    wire ld_begin = chip_full && proc_addr_strobe_n
        && !ctrl_addr_strobe_n;
    // Remaining cycles continue or suspend, other enables unseen
    wire burst = !desel && !rd_begin && !ld_begin;
    wire advance = burst && !burst_advance_n;
    wire suspend = burst && burst_advance_n;

    // Write decode and lane selection
    wire [`SBS_LANES-1:0] lane_mask = narrow_q ? `SBS_MASK_NARROW
        : `SBS_MASK_WIDE;
    wire [`SBS_LANES-1:0] lane_n = {lane3_write_n, lane2_write_n,
        lane1_write_n, lane0_write_n};
    wire write_dec = !global_write_n || !byte_write_gate_n;
    wire [`SBS_LANES-1:0] wr_lanes = !global_write_n ? lane_mask
        : (!byte_write_gate_n ? (~lane_n & lane_mask)
        : {`SBS_LANES{1'b0}});
    wire is_write = (ld_begin || burst) && write_dec;
    wire is_read = rd_begin || ((ld_begin || burst) && !write_dec);

    // Next cycle kind for status
    wire sbs_pkg::sbs_cycle_e kind_d = desel ? sbs_pkg::cyc_desel
        : (rd_begin ? sbs_pkg::cyc_rd_begin
        : (ld_begin ? (write_dec ? sbs_pkg::cyc_wr_begin
        : sbs_pkg::cyc_rd_begin)
        : (advance ? sbs_pkg::cyc_continue : sbs_pkg::cyc_suspend)));

    // Burst counter next state, dummy reads count the same
    wire load = rd_begin || ld_begin;
    wire [`SBS_ADDR_W-1:0] base_d = load ? addr_in : base_q;
    wire sbs_pkg::sbs_step_t step_d = load ? 2'h0
        : (advance ? sbs_pkg::sbs_step_t'(step_q + 2'h1)
        : step_q);
    wire [1:0] lsb_d = !linear_order_sel_n ? 2'(base_d[1:0] + step_d)
        : (base_d[1:0] ^ step_d);
    wire [`SBS_ADDR_W-1:0] addr_d = {base_d[`SBS_ADDR_W-1:2], lsb_d};

    // Burst address and cycle registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            base_q <= '0;
            step_q <= 2'h0;
            mem_addr_q <= '0;
            kind_q <= sbs_pkg::cyc_desel;
        end else if (clk_en) begin
            base_q <= base_d;
            step_q <= step_d;
            if (!desel) begin
                mem_addr_q <= addr_d;
            end
            kind_q <= kind_d;
        end
    end

    // Array strobes and write data capture
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_rd_q <= 1'b0;
            wr_q <= 1'b0;
            mem_wr_lane_q <= '0;
            mem_wdata_q <= '0;
        end else if (clk_en) begin
            mem_rd_q <= is_read;
            wr_q <= is_write;
            mem_wr_lane_q <= is_write ? wr_lanes : '0;
            if (is_write) begin
                mem_wdata_q <= dq_in;
            end
        end
    end

    // Output register stage for pipelined reads
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd2_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            rd2_q <= mem_rd_q;
            if (mem_rd_q) begin
                rdata_q <= mem_rdata;
            end
        end
    end

    // Data drive: sync read window, killed on write, async output enable
    wire drive_sync = flow_through_sel_n ? rd2_q : mem_rd_q;
    wire drive = drive_sync && !wr_q && !output_enable_n;
    assign dq_oe = {`SBS_LANES{drive}} & lane_mask;
    assign dq_out = flow_through_sel_n ? rdata_q : mem_rdata;

    // Wishbone decode
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire hit_ctrl = wb_adr_i == `SBS_REG_CTRL;
    wire hit_stat = wb_adr_i == `SBS_REG_STAT;
    wire hit_addr = wb_adr_i == `SBS_REG_ADDR;
    wire [31:0] stat_word = 32'({linear_order_sel_n, flow_through_sel_n,
        kind_q, step_q});
    wire [31:0] rd_word = hit_ctrl ? {31'h0, narrow_q}
        : (hit_stat ? stat_word
        : (hit_addr ? 32'(mem_addr_q) : 32'h0000_0000));

    // Wishbone answer one cycle after the request
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            narrow_q <= `SBS_CTRL_RST;
        end else if (clk_en) begin
            ack_q <= wb_req;
            if (wb_req) begin
                dat_q <= rd_word;
            end
            if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
                narrow_q <= wb_dat_i[`SBS_CTRL_NARROW];
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Checks on the cycle decode and data drive
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_global_write;
        clk_en && is_write && !global_write_n
            |=> mem_wr_lane_q == $past(lane_mask);
    endproperty
    a_global_write: assert property (p_global_write)
        else $error("global write did not hit every lane");

    property p_byte_write;
        clk_en && is_write && global_write_n && !byte_write_gate_n
            |=> mem_wr_lane_q == (~$past(lane_n) & $past(lane_mask));
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write lanes wrong");

    property p_all_lanes;
        dq_oe == 4'h0 || dq_oe == lane_mask;
    endproperty
    a_all_lanes: assert property (p_all_lanes)
        else $error("read drove a partial set of lanes");

    property p_write_quiet;
        wr_q |-> dq_oe == 4'h0;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("drivers on during write");

    property p_narrow;
        narrow_q && $past(narrow_q)
            |-> dq_oe[3:2] == 2'h0 && mem_wr_lane_q[3:2] == 2'h0;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("absent lane used in narrow mode");

    property p_desel;
        clk_en && desel |=> !mem_rd_q && mem_wr_lane_q == 4'h0;
    endproperty
    a_desel: assert property (p_desel)
        else $error("deselect started an access");

    property p_read_begin;
        clk_en && rd_begin |=> mem_rd_q && !wr_q
            && mem_addr_q == $past(addr_in);
    endproperty
    a_read_begin: assert property (p_read_begin)
        else $error("processor strobe read wrong");

    property p_load;
        clk_en && ld_begin |=> mem_addr_q == $past(addr_in)
            && wr_q == $past(write_dec);
    endproperty
    a_load: assert property (p_load)
        else $error("controller strobe load wrong");

    property p_advance;
        clk_en && advance |=> step_q == 2'($past(step_q) + 2'h1);
    endproperty
    a_advance: assert property (p_advance)
        else $error("advance did not step the counter");

    property p_suspend;
        clk_en && suspend && $stable(linear_order_sel_n)
            |=> mem_addr_q == $past(mem_addr_q);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend moved the address");

    property p_oe_async;
        output_enable_n |-> dq_oe == 4'h0;
    endproperty
    a_oe_async: assert property (p_oe_async)
        else $error("drivers on with output enable high");

    property p_pipe_lag;
        clk_en && flow_through_sel_n && !rd_begin && !ld_begin
            && !burst ##1 clk_en |=> !drive;
    endproperty
    a_pipe_lag: assert property (p_pipe_lag)
        else $error("pipelined deselect did not end drive");

    // Read drive timing, burst wrap and write capture
    property p_read_ignores_write;
        clk_en && rd_begin |=> mem_wr_lane_q == 4'h0;
    endproperty
    a_read_ignores_write: assert property (p_read_ignores_write)
        else $error("processor strobe read wrote a lane");

    property p_first_high_burst;
        clk_en && chip_sel_first_n && ctrl_addr_strobe_n && !burst_advance_n
            |=> step_q == 2'($past(step_q) + 2'h1);
    endproperty
    a_first_high_burst: assert property (p_first_high_burst)
        else $error("processor strobe not ignored with first enable high");

    property p_wrap;
        clk_en && load ##1 (clk_en && advance)[*4]
            |=> mem_addr_q == $past(mem_addr_q, 4);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst did not wrap to its start address");

    property p_flow_drive;
        clk_en && is_read && !flow_through_sel_n
            ##1 !flow_through_sel_n && !output_enable_n
            |-> dq_oe == lane_mask;
    endproperty
    a_flow_drive: assert property (p_flow_drive)
        else $error("flow-through read not driven on every lane");

    property p_pipe_drive;
        clk_en && is_read && flow_through_sel_n ##1 clk_en && !is_write
            ##1 flow_through_sel_n && !output_enable_n
            |-> dq_oe == lane_mask;
    endproperty
    a_pipe_drive: assert property (p_pipe_drive)
        else $error("pipelined read not driven two cycles on");

    property p_pipe_data;
        clk_en && mem_rd_q && flow_through_sel_n
            |=> !flow_through_sel_n || dq_out == $past(mem_rdata);
    endproperty
    a_pipe_data: assert property (p_pipe_data)
        else $error("pipelined data not from the output register");

    property p_write_data;
        clk_en && is_write |=> mem_wdata_q == $past(dq_in);
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("write data not captured with the write cycle");

    property p_ack_pulse;
        clk_en && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus acknowledge held longer than one cycle");

    // Main scenarios
    c_burst4: cover property (clk_en && rd_begin ##1 (clk_en && advance)[*4]);
    c_write_load: cover property (clk_en && ld_begin && write_dec);
    c_suspend: cover property (clk_en && suspend && !write_dec);
    c_dummy_read: cover property (mem_rd_q && output_enable_n);
    c_narrow_read: cover property (narrow_q && dq_oe != 4'h0);

endmodule

// ---- common/sbs_regs.svh ----
// Constants for the synchronous burst memory control block.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
// Array geometry (36-bit data, four 9-bit lanes)
`define SBS_ADDR_W 18
`define SBS_LANE_W 9
`define SBS_LANES 4
`define SBS_DATA_W 36
// Wishbone register map, byte addresses
`define SBS_WB_AW 4
`define SBS_REG_CTRL 4'h0
`define SBS_REG_STAT 4'h4
`define SBS_REG_ADDR 4'h8
// Control register fields and reset value
`define SBS_CTRL_NARROW 0
`define SBS_CTRL_RST 1'b0
// Status register fields
`define SBS_STAT_STEP_LSB 0
`define SBS_STAT_KIND_LSB 2
`define SBS_STAT_FT 5
`define SBS_STAT_LBO 6
// Lane masks for the two widths
`define SBS_MASK_NARROW 4'h3
`define SBS_MASK_WIDE 4'hF
`endif

// ---- common/sbs_pkg.sv ----
// Types shared by the burst memory control block.
package sbs_pkg;
    // Cycle kinds, Gray coded along deselect-read begin-write begin-continue-suspend
    typedef enum logic [2:0] {
        cyc_desel = 3'h0,
        cyc_rd_begin = 3'h1,
        cyc_wr_begin = 3'h3,
        cyc_continue = 3'h2,
        cyc_suspend = 3'h6
    } sbs_cycle_e;
    typedef logic [1:0] sbs_step_t;
endpackage

// ---- tb/sbs_mem_model.sv ----
// Behavioural storage array on the far side of the control block.
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_mem_model (
    // Clock
    input wire logic ref_clk,
    // Array side of the control block
    input wire logic [`SBS_ADDR_W-1:0] mem_addr_q,
    input wire logic [`SBS_LANES-1:0] mem_wr_lane_q,
    input wire logic [`SBS_DATA_W-1:0] mem_wdata_q,
    output logic [`SBS_DATA_W-1:0] mem_rdata
);
    logic [35:0] m [16];
    // Known contents, one word per low address
    initial begin
        for (int i = 0; i < 16; i++) begin
            m[i] = {4'hA, 32'(i)};
        end
    end
    // Lane writes land on the edge after the strobe
    always @(posedge ref_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (mem_wr_lane_q[k]) begin
                m[mem_addr_q[3:0]][k*9+:9] <= mem_wdata_q[k*9+:9];
            end
        end
    end
    // Read data follows the address at once
    assign mem_rdata = m[mem_addr_q[3:0]];
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the burst memory control block.
`timescale 1ns/1ps
`include "sbs_regs.svh"
module tb;
    localparam logic [11:0] c_rdp = 12'h4C0, c_wrc = 12'h55F;
    localparam logic [11:0] c_byt = 12'h56A, c_bno = 12'h56F;
    localparam logic [11:0] c_rdc = 12'h57F, c_con = 12'hABF;
    localparam logic [11:0] c_sus = 12'h5FF, c_des = 12'h17F;
    localparam logic [11:0] c_ds2 = 12'hD7F;
    localparam logic [35:0] c_d1 = 36'h912345678;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic ack;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rv;
    logic [11:0] pc = c_des;
    logic ft_n = 1'b1;
    logic lo_n = 1'b0;
    logic oe_n = 1'b0;
    logic ce = 1'b1;
    logic mrd;
    logic [17:0] addr = 18'h0;
    logic [17:0] maddr;
    logic [35:0] din = 36'h0;
    logic [35:0] dq_out, wdata, rdata;
    logic [3:0] dq_oe, wr_lane;
    int num_errors = 0;
    int num_checks = 0;
    // Free-running clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    sbs_ctrl dut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .chip_sel_first_n(pc[11]), .chip_sel_second(pc[10]),
        .chip_sel_third_n(pc[9]), .proc_addr_strobe_n(pc[8]),
        .ctrl_addr_strobe_n(pc[7]), .burst_advance_n(pc[6]),
        .global_write_n(pc[5]), .byte_write_gate_n(pc[4]),
        .lane0_write_n(pc[0]), .lane1_write_n(pc[1]),
        .lane2_write_n(pc[2]), .lane3_write_n(pc[3]),
        .flow_through_sel_n(ft_n), .linear_order_sel_n(lo_n),
        .output_enable_n(oe_n), .addr_in(addr), .dq_in(din),
        .dq_out(dq_out), .dq_oe(dq_oe), .mem_addr_q(maddr),
        .mem_rd_q(mrd), .mem_wr_lane_q(wr_lane), .mem_wdata_q(wdata),
        .mem_rdata(rdata)
    );
    sbs_mem_model mem (
        .ref_clk(ref_clk), .mem_addr_q(maddr), .mem_wr_lane_q(wr_lane),
        .mem_wdata_q(wdata), .mem_rdata(rdata)
    );
    task automatic chk(string n, logic [35:0] seen, logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Classic single cycle, held until ack is sampled high
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rv = rdat;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask
    // One pin cycle; outputs seen show the previous cycle's effect
    task automatic step(logic [11:0] p, logic [17:0] a, logic [35:0] d);
        @(posedge ref_clk);
        pc <= p;
        addr <= a;
        din <= d;
        @(negedge ref_clk);
    endtask
    // Read burst: begin, four continues with wrap, suspend, deselect
    task automatic burst(logic lo, logic ft, logic oe, logic [1:0] s);
        logic [1:0] j, e;
        logic [3:0] xo;
        logic [35:0] pd;
        @(posedge ref_clk);
        lo_n <= lo;
        ft_n <= ft;
        oe_n <= oe;
        pd = 36'h0;
        step(c_rdp, {16'h0, s}, 36'h0);
        for (int i = 0; i < 6; i++) begin
            step(i < 4 ? c_con : (i == 4 ? c_sus : c_des), 18'h3FFFF, 36'h0);
            j = (i < 4) ? 2'(i) : 2'h0;
            e = lo ? s ^ j : s + j;
            xo = (oe || (ft && i == 0)) ? 4'h0 : 4'hF;
            chk("burst_addr", 36'(maddr), 36'(e));
            chk("burst_oe", 36'(dq_oe), 36'(xo));
            if (xo == 4'hF) begin
                chk("burst_dq", dq_out, ft ? pd : {4'hA, 30'h0, e});
            end
            pd = {4'hA, 30'h0, e};
        end
        step(c_des, 18'h0, 36'h0);
        chk("desel_rd", 36'(mrd), 36'h0);
        chk("desel_addr", 36'(maddr), 36'(e));
        chk("desel_oe", 36'(dq_oe), (ft && !oe) ? 36'hF : 36'h0);
        step(c_des, 18'h0, 36'h0);
        chk("desel_off", 36'(dq_oe), 36'h0);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        wb(1'b0, `SBS_REG_CTRL, 32'h0);
        chk("ctrl", 36'(rv), 36'h0);
        wb(1'b0, `SBS_REG_STAT, 32'h0);
        chk("stat", 36'(rv), 36'h20);
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped", 36'(rv), 36'h0);
        burst(1'b0, 1'b0, 1'b0, 2'h2);
        burst(1'b1, 1'b1, 1'b0, 2'h1);
        burst(1'b0, 1'b1, 1'b1, 2'h3);
        @(posedge ref_clk);
        oe_n <= 1'b0;
        step(c_wrc, 18'h5, c_d1);
        step(c_byt, 18'h6, 36'hFFFFFFFFF);
        chk("wr_lane", 36'(wr_lane), 36'hF);
        chk("wdata", wdata, c_d1);
        chk("wr_oe", 36'(dq_oe), 36'h0);
        step(c_bno, 18'h7, 36'h0);
        chk("byte_lanes", 36'(wr_lane), 36'h5);
        chk("wr_addr", 36'(maddr), 36'h6);
        chk("byte_oe", 36'(dq_oe), 36'h0);
        step(c_des, 18'h0, 36'h0);
        chk("no_lanes", 36'(wr_lane), 36'h0);
        chk("wr_no_rd", 36'(mrd), 36'h0);
        @(posedge ref_clk);
        ft_n <= 1'b0;
        step(c_rdc, 18'h5, 36'h0);
        step(c_rdc, 18'h6, 36'h0);
        chk("rd_word", dq_out, c_d1);
        step(c_ds2, 18'h0, 36'h0);
        chk("rd_bytes", dq_out, 36'hA07FC01FF);
        step(c_des, 18'h0, 36'h0);
        chk("ds2_off", 36'(dq_oe), 36'h0);
        wb(1'b0, `SBS_REG_ADDR, 32'h0);
        chk("addr_reg", 36'(rv), 36'h6);
        wb(1'b1, `SBS_REG_CTRL, 32'h1);
        step(c_rdc, 18'h1, 36'h0);
        step(c_des, 18'h0, 36'h0);
        chk("narrow_oe", 36'(dq_oe), 36'h3);
        // Clock enable low must freeze the address and read flag
        @(posedge ref_clk);
        ce <= 1'b0;
        step(c_rdc, 18'h2, 36'h0);
        step(c_des, 18'h0, 36'h0);
        chk("freeze_addr", 36'(maddr), 36'h1);
        chk("freeze_rd", 36'(mrd), 36'h0);
        @(posedge ref_clk);
        ce <= 1'b1;
        wb(1'b1, `SBS_REG_CTRL, 32'h0);
        final_report();
    end
endmodule
